// ### resampler_output_pkg.sv
// constants and types shared by the resampler output interface
package resampler_output_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int SAMPLE_W = 10;
    localparam int OFS_W = 32;
    localparam int ACC_W = 32;
    localparam int SPH_W = 5;
    localparam int CTRL_W = 6;
    localparam int DIV_W = 8;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BASE_FREQ = 8'h04;
    localparam logic [7:0] ADDR_BIT_DIV = 8'h08;
    localparam logic [7:0] ADDR_OFFSET = 8'h0C;
    localparam logic [7:0] ADDR_PHASE = 8'h10;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int CTRL_SERIAL = 0;
    localparam int CTRL_RDY_LOW = 1;
    localparam int CTRL_SAMPLED = 2;
    localparam int CTRL_STATIC_LVL = 3;
    localparam int CTRL_WIN_LSB = 4;
    localparam int WIN_W = 2;

    // top eight accumulator bits
    localparam int PHASE_TOP_LSB = 24;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [ACC_W-1:0] BASE_FREQ_RST = 32'h0000_0000;
    localparam logic [DIV_W-1:0] BIT_DIV_RST = 8'h01;
    localparam logic [OFS_W-1:0] OFFSET_RST = 32'h0000_0000;

    // ****************************************
    // serial formatter states
    // ****************************************
    typedef enum logic [1:0] {SER_IDLE, SER_LEAD, SER_SHIFT} ser_state_t;

endpackage : resampler_output_pkg

// ### resampler_output_interface.sv
// resampler offset link, I/Q output formatter and symbol timing outputs
//
// Summary of operation
// [RQ1] offset word shifts in MSB first, one bit per clock after sync.
// [RQ2] tracking loop raises offset sync one clock before the offset MSB.
// [RQ3] I/Q buses are registered; bit 9 is MSB in parallel mode.
// [RQ4] serial mode: I data bit 0, bit clock I bit 9, Q data bit 0.
// [RQ5] serial mode: other bus pins sit at a chosen static level.
// [RQ6] parallel mode: data ready asserts in first cycle of a new sample.
// [RQ7] data ready polarity is selected in the control register.
// [RQ8] serial mode: data ready leads the first data bit by one bit period.
// [RQ9] in-phase enable high floats the whole in-phase bus.
// [RQ10] quadrature enable high floats the whole quadrature bus.
// [RQ11] all pins clocked except the two combinational output enables; output_data_ready is also the ready flop XOR the polarity bit.
// [RQ12] continuous mode: strobe is the resampler oscillator carry.
// [RQ13] sampled mode: strobe asserts with data ready at the boundary sample.
// [RQ14] five phase bits from accumulator top eight, window chosen in control.
// [RQ15] continuous mode: phase outputs follow the accumulator every clock.
// [RQ16] sampled mode: phase outputs change only with the strobe asserted.
// [RQ17] offset word applies only once complete; old one kept.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps

module resampler_output_interface
    import resampler_output_pkg::*;
(
    // system clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // offset link, on its own clock
    input wire logic link_clk,
    input wire logic resampler_offset_sync,
    input wire logic resampler_offset_serial,
    // baseband samples from the filter chain
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic [SAMPLE_W-1:0] sample_q,
    input wire logic sample_valid,
    // output buses
    input wire logic inphase_output_enable_n,
    input wire logic quadrature_output_enable_n,
    output logic [SAMPLE_W-1:0] inphase_out_bus,
    output logic inphase_out_bus_oe_n,
    output logic [SAMPLE_W-1:0] quadrature_out_bus,
    output logic quadrature_out_bus_oe_n,
    output logic output_data_ready,
    // symbol timing
    output logic symbol_sample_strobe,
    output logic [SPH_W-1:0] sample_phase_out
);

    localparam int CNT_W = $clog2(OFS_W + 1);
    localparam int BIT_CNT_W = $clog2(SAMPLE_W + 1);

    // ****************************************
    // link domain: serial offset capture
    // ****************************************
    logic lk_rst_meta_q;
    logic lk_rst_q;
    logic [OFS_W-1:0] lk_shift_q, lk_shift_d;
    logic [OFS_W-1:0] lk_word_q, lk_word_d;
    logic [CNT_W-1:0] lk_cnt_q, lk_cnt_d;
    logic lk_busy_q, lk_busy_d;
    logic lk_toggle_q, lk_toggle_d;

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lk_rst_meta_q <= 1'b1;
            lk_rst_q <= 1'b1;
        end else begin
            lk_rst_meta_q <= 1'b0;
            lk_rst_q <= lk_rst_meta_q;
        end
    end

    always_comb begin
        lk_shift_d = lk_shift_q;
        lk_word_d = lk_word_q;
        lk_cnt_d = lk_cnt_q;
        lk_busy_d = lk_busy_q;
        lk_toggle_d = lk_toggle_q;
        if (resampler_offset_sync) begin
            // next cycle carries the MSB [RQ1] [RQ2]
            lk_busy_d = 1'b1;
            lk_cnt_d = '0;
        end else if (lk_busy_q) begin
            lk_shift_d = {lk_shift_q[OFS_W-2:0], resampler_offset_serial}; // [RQ1]
            lk_cnt_d = lk_cnt_q + 1'b1;
            if (lk_cnt_q == CNT_W'(OFS_W - 1)) begin
                // word complete: publish [RQ17]
                lk_busy_d = 1'b0;
                lk_word_d = {lk_shift_q[OFS_W-2:0], resampler_offset_serial};
                lk_toggle_d = ~lk_toggle_q;
            end
        end
    end

    always_ff @(posedge link_clk or posedge lk_rst_q) begin
        if (lk_rst_q) begin
            lk_shift_q <= '0;
            lk_word_q <= OFFSET_RST;
            lk_cnt_q <= '0;
            lk_busy_q <= 1'b0;
            lk_toggle_q <= 1'b0;
        end else begin
            lk_shift_q <= lk_shift_d;
            lk_word_q <= lk_word_d;
            lk_cnt_q <= lk_cnt_d;
            lk_busy_q <= lk_busy_d;
            lk_toggle_q <= lk_toggle_d;
        end
    end

    // ****************************************
    // crossing: toggle synchroniser, word held stable
    // ****************************************
    // word changes once per word time,
    // so it is static when sampled
    logic tog_meta_q, tog_sync_q, tog_seen_q;
    logic load_offset;
    logic [OFS_W-1:0] offset_q, offset_d;

    assign load_offset = tog_sync_q ^ tog_seen_q;

    always_comb begin
        offset_d = load_offset ? lk_word_q : offset_q; // [RQ17]
    end

    // ****************************************
    // ahb-lite register slave
    // ****************************************
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [ACC_W-1:0] base_q, base_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [7:0] dp_addr_q, dp_addr_d;
    logic dp_write_q, dp_write_d;
    logic dp_read_q, dp_read_d;
    logic [ACC_W-1:0] acc_q, acc_d;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        dp_addr_d = dp_addr_q;
        dp_write_d = 1'b0;
        dp_read_d = 1'b0;
        if (hsel && hready && htrans[1]) begin
            dp_addr_d = haddr;
            dp_write_d = hwrite;
            dp_read_d = ~hwrite;
        end
        ctrl_d = ctrl_q;
        base_d = base_q;
        div_d = div_q;
        if (dp_write_q) begin
            unique case (dp_addr_q)
                ADDR_CTRL: ctrl_d = hwdata[CTRL_W-1:0];
                ADDR_BASE_FREQ: base_d = hwdata;
                ADDR_BIT_DIV: div_d = hwdata[DIV_W-1:0];
                default: ;
            endcase
        end
    end

    // read data straight from the registers
    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_read_q) begin
            unique case (dp_addr_q)
                ADDR_CTRL: hrdata = {{(32-CTRL_W){1'b0}}, ctrl_q};
                ADDR_BASE_FREQ: hrdata = base_q;
                ADDR_BIT_DIV: hrdata = {{(32-DIV_W){1'b0}}, div_q};
                ADDR_OFFSET: hrdata = offset_q;
                ADDR_PHASE: hrdata = acc_q;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // resampler oscillator and symbol timing
    // ****************************************
    logic serial_mode, rdy_low, sampled_mode, static_lvl;
    logic [WIN_W-1:0] win_sel;
    logic carry_q, carry_d;
    logic pend_q, pend_d;
    logic strobe_q, strobe_d;
    logic [SPH_W-1:0] sph_q, sph_d;
    logic [SPH_W-1:0] sph_win;
    logic new_word;

    assign serial_mode = ctrl_q[CTRL_SERIAL];
    assign rdy_low = ctrl_q[CTRL_RDY_LOW];
    assign sampled_mode = ctrl_q[CTRL_SAMPLED];
    assign static_lvl = ctrl_q[CTRL_STATIC_LVL];
    assign win_sel = ctrl_q[CTRL_WIN_LSB +: WIN_W];
    assign sph_win = acc_q[PHASE_TOP_LSB + int'(win_sel) +: SPH_W]; // [RQ14]

    always_comb begin
        {carry_d, acc_d} = {1'b0, acc_q} + {1'b0, base_q} + {1'b0, offset_q};
        pend_d = pend_q | carry_q;
        if (sampled_mode) begin
            // wait for the next output word [RQ13]
            strobe_d = new_word && pend_d;
            if (new_word) begin
                pend_d = 1'b0;
            end
            sph_d = strobe_d ? sph_win : sph_q; // [RQ16]
        end else begin
            strobe_d = carry_q; // [RQ12]
            pend_d = 1'b0;
            sph_d = sph_win; // [RQ15]
        end
    end

    // ****************************************
    // output formatter
    // ****************************************
    ser_state_t ser_state_q, ser_state_d;
    logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
    logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
    logic bclk_q, bclk_d;
    logic [SAMPLE_W-1:0] sh_i_q, sh_i_d, sh_q_q, sh_q_d;
    logic [SAMPLE_W-1:0] ibus_q, ibus_d, qbus_q, qbus_d;
    logic rdy_act_q, rdy_act_d;
    logic period_end, half_end;

    assign half_end = (div_cnt_q == div_q);
    assign period_end = half_end && bclk_q;

    // words arriving mid-shift are dropped;
    // keep the bit divider small so a word is shifted out before the next sample
    assign new_word = serial_mode ? (ser_state_q == SER_IDLE && sample_valid) : sample_valid;

    always_comb begin
        ser_state_d = ser_state_q;
        div_cnt_d = half_end ? '0 : div_cnt_q + 1'b1;
        bclk_d = half_end ? ~bclk_q : bclk_q;
        bit_cnt_d = bit_cnt_q;
        sh_i_d = sh_i_q;
        sh_q_d = sh_q_q;
        ibus_d = ibus_q;
        qbus_d = qbus_q;
        rdy_act_d = 1'b0;
        if (!serial_mode) begin
            ser_state_d = SER_IDLE;
            bclk_d = 1'b0;
            div_cnt_d = '0;
            if (sample_valid) begin
                ibus_d = sample_i; // [RQ3]
                qbus_d = sample_q;
                rdy_act_d = 1'b1; // [RQ6]
            end
        end else begin
            ibus_d[SAMPLE_W-2:1] = {(SAMPLE_W-2){static_lvl}}; // [RQ5]
            qbus_d[SAMPLE_W-1:1] = {(SAMPLE_W-1){static_lvl}}; // [RQ5]
            unique case (ser_state_q)
                SER_IDLE: begin
                    bclk_d = 1'b0;
                    div_cnt_d = '0;
                    if (sample_valid) begin
                        sh_i_d = sample_i;
                        sh_q_d = sample_q;
                        bit_cnt_d = '0;
                        ser_state_d = SER_LEAD;
                        rdy_act_d = 1'b1; // [RQ8]
                    end
                end
                SER_LEAD: begin
                    // ready leads the MSB by one period
                    rdy_act_d = ~period_end; // [RQ8]
                    if (period_end) begin
                        ser_state_d = SER_SHIFT;
                    end
                end
                SER_SHIFT: begin
                    if (period_end) begin
                        sh_i_d = {sh_i_q[SAMPLE_W-2:0], 1'b0};
                        sh_q_d = {sh_q_q[SAMPLE_W-2:0], 1'b0};
                        bit_cnt_d = bit_cnt_q + 1'b1;
                        if (bit_cnt_q == BIT_CNT_W'(SAMPLE_W - 1)) begin
                            ser_state_d = SER_IDLE;
                        end
                    end
                end
                default: ser_state_d = SER_IDLE;
            endcase
            ibus_d[SAMPLE_W-1] = bclk_d; // [RQ4]
            ibus_d[0] = (ser_state_d == SER_SHIFT) ? sh_i_d[SAMPLE_W-1] : static_lvl; // [RQ4]
            qbus_d[0] = (ser_state_d == SER_SHIFT) ? sh_q_d[SAMPLE_W-1] : static_lvl;
        end
    end

    // ****************************************
    // registers of the system domain
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tog_meta_q <= 1'b0;
            tog_sync_q <= 1'b0;
            tog_seen_q <= 1'b0;
            offset_q <= OFFSET_RST;
            dp_addr_q <= 8'h00;
            dp_write_q <= 1'b0;
            dp_read_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            base_q <= BASE_FREQ_RST;
            div_q <= BIT_DIV_RST;
            acc_q <= '0;
            carry_q <= 1'b0;
            pend_q <= 1'b0;
            strobe_q <= 1'b0;
            sph_q <= '0;
            ser_state_q <= SER_IDLE;
            div_cnt_q <= '0;
            bit_cnt_q <= '0;
            bclk_q <= 1'b0;
            sh_i_q <= '0;
            sh_q_q <= '0;
            ibus_q <= '0;
            qbus_q <= '0;
            rdy_act_q <= 1'b0;
        end else begin
            tog_meta_q <= lk_toggle_q;
            tog_sync_q <= tog_meta_q;
            tog_seen_q <= tog_sync_q;
            offset_q <= offset_d;
            dp_addr_q <= dp_addr_d;
            dp_write_q <= dp_write_d;
            dp_read_q <= dp_read_d;
            ctrl_q <= ctrl_d;
            base_q <= base_d;
            div_q <= div_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            pend_q <= pend_d;
            strobe_q <= strobe_d;
            sph_q <= sph_d;
            ser_state_q <= ser_state_d;
            div_cnt_q <= div_cnt_d;
            bit_cnt_q <= bit_cnt_d;
            bclk_q <= bclk_d;
            sh_i_q <= sh_i_d;
            sh_q_q <= sh_q_d;
            ibus_q <= ibus_d;
            qbus_q <= qbus_d;
            rdy_act_q <= rdy_act_d;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    assign inphase_out_bus = ibus_q;
    assign quadrature_out_bus = qbus_q;
    assign inphase_out_bus_oe_n = inphase_output_enable_n; // [RQ9] [RQ11]
    assign quadrature_out_bus_oe_n = quadrature_output_enable_n; // [RQ10] [RQ11]
    assign output_data_ready = rdy_act_q ^ rdy_low; // [RQ7]
    assign symbol_sample_strobe = strobe_q;
    assign sample_phase_out = sph_q;

    // ****************************************
    // assertions
    // ****************************************
    sequence s_sync_then_msb;
        resampler_offset_sync ##1 !resampler_offset_sync;
    endsequence

    property p_offset_start;
        @(posedge link_clk) disable iff (lk_rst_q)
        s_sync_then_msb |-> lk_busy_q && lk_cnt_q == '0;
    endproperty
    a_offset_start: assert property (p_offset_start) else $error("no shift start"); // [RQ1]

    property p_offset_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        !load_offset |=> $stable(offset_q);
    endproperty
    a_offset_hold: assert property (p_offset_hold) else $error("offset moved"); // [RQ17]

    property p_par_ready;
        @(posedge clk_sys) disable iff (sys_rst)
        !serial_mode && sample_valid && !dp_write_q
            |=> rdy_act_q && ibus_q == $past(sample_i) && qbus_q == $past(sample_q);
    endproperty
    a_par_ready: assert property (p_par_ready) else $error("no ready"); // [RQ6]

    property p_polarity;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(rdy_act_q) && $stable(rdy_low) |-> output_data_ready == !rdy_low;
    endproperty
    a_polarity: assert property (p_polarity) else $error("bad polarity"); // [RQ7]

    property p_serial_lead;
        @(posedge clk_sys) disable iff (sys_rst)
        ser_state_q == SER_LEAD ##1 ser_state_q == SER_SHIFT |-> $past(rdy_act_q, 2) && !rdy_act_q;
    endproperty
    a_serial_lead: assert property (p_serial_lead) else $error("no lead"); // [RQ8]

    property p_cont_strobe;
        @(posedge clk_sys) disable iff (sys_rst)
        !sampled_mode |=> symbol_sample_strobe == $past(carry_q);
    endproperty
    a_cont_strobe: assert property (p_cont_strobe) else $error("not carry"); // [RQ12]

    property p_sampled_strobe;
        @(posedge clk_sys) disable iff (sys_rst)
        sampled_mode ##1 symbol_sample_strobe |-> rdy_act_q;
    endproperty
    a_sampled_strobe: assert property (p_sampled_strobe) else $error("lone strobe"); // [RQ13]

    property p_phase_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        sampled_mode ##1 !symbol_sample_strobe |-> $stable(sample_phase_out);
    endproperty
    a_phase_hold: assert property (p_phase_hold) else $error("phase moved"); // [RQ16]

    property p_cont_phase;
        @(posedge clk_sys) disable iff (sys_rst)
        !sampled_mode |=> sample_phase_out == $past(sph_win);
    endproperty
    a_cont_phase: assert property (p_cont_phase) else $error("phase stuck"); // [RQ15]

    property p_serial_pins;
        @(posedge clk_sys) disable iff (sys_rst)
        serial_mode && !dp_write_q |=> qbus_q[SAMPLE_W-1:1] == {(SAMPLE_W-1){static_lvl}};
    endproperty
    a_serial_pins: assert property (p_serial_pins) else $error("bad pins"); // [RQ5]

endmodule : resampler_output_interface

// ### resampler_tracking_loop.sv
// symbol tracking loop model that drives the resampler offset link
`timescale 1ns/100ps

module resampler_tracking_loop (
    // link clock and reset
    input wire logic link_clk,
    input wire logic sys_rst,
    // request from the bench
    input wire logic go,
    input wire logic [31:0] word,
    input wire logic [5:0] nbits,
    input wire logic [3:0] gap,
    // offset link
    output logic resampler_offset_sync,
    output logic resampler_offset_serial,
    output logic done
);
    int cnt;

    always @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 0;
            resampler_offset_sync <= 1'b0;
            resampler_offset_serial <= 1'b0;
            done <= 1'b0;
        end else begin
            resampler_offset_sync <= 1'b0;
            // toggles between words
            resampler_offset_serial <= ~resampler_offset_serial;
            if (!go) begin
                cnt <= 0;
                done <= 1'b0;
            end else if (!done) begin
                cnt <= cnt + 1;
                if (cnt == gap) begin
                    resampler_offset_sync <= 1'b1;
                end else if (cnt > gap && cnt <= gap + nbits) begin
                    resampler_offset_serial <= word[31 - (cnt - gap - 1)];
                end else if (cnt > gap) begin
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : resampler_tracking_loop

// ### tb_top.sv
// self-checking bench for the resampler output interface
`timescale 1ns/100ps

module tb_top;
    import resampler_output_pkg::*;
    logic clk_sys = 0, sys_rst = 1, link_clk = 0;
    logic hsel = 0, hwrite = 0, sample_valid = 0, go = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, word = 32'h0000_0000;
    logic hreadyout, hresp, sync, ser, done, oe_i_n = 0, oe_q_n = 0, i_oe_n, q_oe_n;
    logic [9:0] sample_i = 10'h000, sample_q = 10'h000, bus_i, bus_q;
    logic [5:0] nbits = 6'h20;
    logic [3:0] gap = 4'h0;
    logic rdy, strb;
    logic [4:0] phase;
    wire logic [9:0] pins_i = i_oe_n ? 10'bzzzz_zzzz_zz : bus_i;
    int n_mismatch = 0, checks = 0;

    always #4 clk_sys = ~clk_sys;
    always #62.5 link_clk = ~link_clk;

    resampler_output_interface dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_clk(link_clk), .resampler_offset_sync(sync), .resampler_offset_serial(ser),
        .sample_i(sample_i), .sample_q(sample_q), .sample_valid(sample_valid),
        .inphase_output_enable_n(oe_i_n), .quadrature_output_enable_n(oe_q_n),
        .inphase_out_bus(bus_i), .inphase_out_bus_oe_n(i_oe_n), .quadrature_out_bus(bus_q),
        .quadrature_out_bus_oe_n(q_oe_n), .output_data_ready(rdy),
        .symbol_sample_strobe(strb), .sample_phase_out(phase));

    resampler_tracking_loop loop_model (.link_clk(link_clk), .sys_rst(sys_rst), .go(go),
        .word(word), .nbits(nbits), .gap(gap), .resampler_offset_sync(sync),
        .resampler_offset_serial(ser), .done(done));

    // ****************************************
    // shared tasks
    // ****************************************
    task test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task fail(input string m);
        chk(1'b0, 1'b1, m);
        test_done;
    endtask : fail

    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) fail("bus hang");
    endtask : ahb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(a, 1'b1, d, x);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] r);
        ahb(a, 1'b0, 32'h0000_0000, r);
    endtask : rd

    task send(input logic [31:0] w, input logic [5:0] nb, input logic [3:0] g);
        int n;
        @(posedge clk_sys);
        go <= 1'b1;
        word <= w;
        nbits <= nb;
        gap <= g;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (done !== 1'b1 && n < 1000);
        go <= 1'b0;
        do begin @(posedge clk_sys); n++; end while (done !== 1'b0 && n < 1100);
        if (n >= 1100) fail("offset link hang");
    endtask : send

    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        logic [31:0] r;
        rd(ADDR_CTRL, r);
        chk(r, {26'h000_0000, CTRL_RST}, "ctrl reset");
        rd(ADDR_BASE_FREQ, r);
        chk(r, BASE_FREQ_RST, "base reset");
        rd(ADDR_BIT_DIV, r);
        chk(r, {24'h00_0000, BIT_DIV_RST}, "divider reset");
        wr(ADDR_OFFSET, 32'hFFFF_FFFF);
        rd(ADDR_OFFSET, r);
        chk(r, OFFSET_RST, "offset read only");
        wr(8'h14, 32'h1234_5678);
        rd(8'h14, r);
        chk(r, 32'h0000_0000, "unmapped read");
        $display("test regs done");
    endtask : t_regs

    task t_strobe;
        int n;
        logic [4:0] p;
        wr(ADDR_BASE_FREQ, 32'h1000_0000);
        repeat (3) @(posedge clk_sys);
        #1 p = phase;
        n = 0;
        for (int k = 0; k < 64; k++) begin
            @(posedge clk_sys);
            #1 n += (strb === 1'b1);
            chk(phase ^ p, 5'h10, "phase w0");
            p = phase;
        end
        chk(n, 4, "carry count");
        wr(ADDR_CTRL, 32'h0000_0030);
        repeat (3) @(posedge clk_sys);
        #1 p = phase;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            #1 chk(5'(phase - p), 5'h02, "phase w3");
            p = phase;
        end
        wr(ADDR_CTRL, 32'h0000_0004);
        #1 p = phase;
        n = 0;
        for (int k = 0; k < 80; k++) begin
            @(posedge clk_sys);
            sample_valid <= (k % 5 == 0);
            #1 if (strb === 1'b1) begin
                n++;
                chk(rdy, 1'b1, "strobe ready");
            end else if (phase !== p) begin
                chk(0, 1, "phase held");
            end
            p = phase;
        end
        sample_valid <= 1'b0;
        chk(n >= 4 && n <= 6, 1, "strobe count");
        $display("test strobe done");
    endtask : t_strobe

    task t_parallel;
        for (int pol = 0; pol < 2; pol++) begin
            wr(ADDR_CTRL, pol << CTRL_RDY_LOW);
            @(posedge clk_sys);
            sample_valid <= 1'b1;
            sample_i <= 10'h2A5;
            sample_q <= 10'h15A;
            @(posedge clk_sys);
            sample_i <= 10'h15A;
            sample_q <= 10'h2A5;
            #1 chk({bus_i, bus_q}, 20'hA_955A, "first sample");
            chk(rdy, pol == 0, "ready");
            @(posedge clk_sys);
            sample_valid <= 1'b0;
            #1 chk({bus_i, bus_q}, 20'h5_6AA5, "second sample");
            chk(rdy, pol == 0, "ready again");
            @(posedge clk_sys);
            #1 chk(rdy, pol != 0, "ready idle");
        end
        $display("test parallel done");
    endtask : t_parallel

    task t_enables;
        @(posedge clk_sys);
        oe_i_n <= 1'b1;
        #1 chk(pins_i, 10'bzzzz_zzzz_zz, "inphase float");
        chk({i_oe_n, q_oe_n}, 2'b10, "i off");
        @(posedge clk_sys);
        oe_i_n <= 1'b0;
        oe_q_n <= 1'b1;
        #1 chk({i_oe_n, q_oe_n}, 2'b01, "q off");
        @(posedge clk_sys);
        oe_q_n <= 1'b0;
        $display("test enables done");
    endtask : t_enables

    task t_serial;
        int nr;
        logic pc;
        logic [9:0] gi, gq;
        wr(ADDR_BIT_DIV, 32'h0000_0001);
        wr(ADDR_CTRL, 32'h0000_0009);
        @(posedge clk_sys);
        sample_valid <= 1'b1;
        sample_i <= 10'h2C9;
        sample_q <= 10'h136;
        @(posedge clk_sys);
        sample_valid <= 1'b0;
        #1 pc = bus_i[9];
        nr = 0;
        for (int k = 0; k < 120 && nr < 11; k++) begin
            @(posedge clk_sys);
            #1 if (bus_i[9] === 1'b1 && pc === 1'b0) begin
                chk(rdy, nr == 0, "ready lead period");
                gi = {gi[8:0], bus_i[0]};
                gq = {gq[8:0], bus_q[0]};
                nr++;
            end
            pc = bus_i[9];
            chk({bus_i[8:1], bus_q[9:1]}, 17'h1_FFFF, "static pins");
        end
        chk({gi, gq}, 20'hB_2536, "serial words");
        wr(ADDR_CTRL, 32'h0000_0000);
        $display("test serial done");
    endtask : t_serial

    task t_offset;
        logic [31:0] r;
        int n;
        wr(ADDR_BASE_FREQ, 32'h0000_0000);
        send(32'hA5C3_1E97, 6'h20, 4'h3);
        n = 0;
        do begin rd(ADDR_OFFSET, r); n++; end while (r !== 32'hA5C3_1E97 && n < 30);
        chk(r, 32'hA5C3_1E97, "offset 1");
        send(32'h1234_5678, 6'h0C, 4'h0);
        repeat (40) @(posedge clk_sys);
        rd(ADDR_OFFSET, r);
        chk(r, 32'hA5C3_1E97, "partial kept out");
        send(32'h5A3C_E169, 6'h20, 4'h0);
        n = 0;
        do begin rd(ADDR_OFFSET, r); n++; end while (r !== 32'h5A3C_E169 && n < 30);
        chk(r, 32'h5A3C_E169, "offset 2");
        $display("test offset done");
    endtask : t_offset

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        // long enough for three link edges
        repeat (48) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs;
        t_strobe;
        t_parallel;
        t_enables;
        t_serial;
        t_offset;
        test_done;
    end
endmodule : tb_top
